// ### dchs_defs.svh
// Constants for the dual channel host select block.
// Assumes inclusion by bare name; definitions only.
`ifndef DCHS_DEFS_SVH
`define DCHS_DEFS_SVH
`define DCHS_NUM_REGS 8
`define DCHS_ADDR_W 3
`define DCHS_DATA_W 8
`define DCHS_ADDR_MSR 3'h6
`define DCHS_ADDR_EFR 3'h2
`define DCHS_ADDR_AFR 3'h1
`define DCHS_MSR_CTS_BIT 4
`define DCHS_MSR_CD_BIT 7
`define DCHS_EFR_AUTO_CTS_BIT 7
`define DCHS_AFR_BCAST_BIT 0
`define DCHS_REG_RESET 8'h00
`endif

// ### dchs_pkg.sv
// Types for the dual channel host select block.
// Assumes dchs_defs.svh alongside.
`include "dchs_defs.svh"
package dchs_pkg;
  typedef logic [`DCHS_DATA_W-1:0] dchs_byte_t;
  typedef logic [`DCHS_ADDR_W-1:0] dchs_addr_t;
  typedef enum logic [1:0] {
    DCHS_IDLE = 2'h0,
    DCHS_READ = 2'h1,
    DCHS_WRITE = 2'h3
  } dchs_phase_e;
endpackage

// ### dchs_chan_regs.sv
// One channel's register set with modem status view.
// Assumes write strobe and address come from the host select top.
`timescale 1ns/1ps
`include "dchs_defs.svh"
module dchs_chan_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire dchs_pkg::dchs_addr_t i_addr,
  input wire dchs_pkg::dchs_byte_t i_wdata,
  input wire logic i_cd_n,
  input wire logic i_cts_n,
  output dchs_pkg::dchs_byte_t o_rdata,
  output logic o_auto_cts,
  output logic o_bcast
);
  typedef struct packed {
    dchs_pkg::dchs_byte_t [`DCHS_NUM_REGS-1:0] regs;
  } dchs_chan_s;
  dchs_chan_s st_reg;
  dchs_chan_s st_next;

  always_comb begin
    st_next = st_reg;
    if (i_wr && i_addr != `DCHS_ADDR_MSR) begin
      st_next.regs[i_addr] = i_wdata;
    end
    // Modem status tracks the pins; a low pin reads as a one
    st_next.regs[`DCHS_ADDR_MSR] = `DCHS_REG_RESET;
    st_next.regs[`DCHS_ADDR_MSR][`DCHS_MSR_CD_BIT] = ~i_cd_n;
    st_next.regs[`DCHS_ADDR_MSR][`DCHS_MSR_CTS_BIT] = ~i_cts_n;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.regs[i_addr];
  assign o_auto_cts =
    st_reg.regs[`DCHS_ADDR_EFR][`DCHS_EFR_AUTO_CTS_BIT];
  assign o_bcast = st_reg.regs[`DCHS_ADDR_AFR][`DCHS_AFR_BCAST_BIT];

  msr_cts_a: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) 1'b1 |=>
    st_reg.regs[`DCHS_ADDR_MSR][`DCHS_MSR_CTS_BIT] == !$past(i_cts_n))
    else $error("cts status wrong");
  msr_cd_a: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) 1'b1 |=>
    st_reg.regs[`DCHS_ADDR_MSR][`DCHS_MSR_CD_BIT] == !$past(i_cd_n))
    else $error("carrier status wrong");
endmodule

// ### dchs_host_select.sv
// Host port of a dual serial device: select, steering, modem status.
// Assumes host strobes synchronous to I_MCLK and held several cycles.
// How it works
// - Three address pins pick the register inside the chosen channel.
// - Accesses count only while chip select is low.
// - Channel pick 0 selects channel B, 1 selects channel A.
// - Channel pick is looked at only while chip select is low.
// - Broadcast bit in channel A alt function register writes both channels.
// - Low carrier detect reads as one in modem status.
// - Low clear to send means far modem is ready.
// - Clear to send shows in modem status bit 4.
// - Clear to send gates transmit only when auto mode bit 7 set.
// - Read strobe falling edge puts addressed register on data bus.
// - Write strobe rising edge stores data bus into chosen register.
// - Data bus bit 0 is least significant and first serial bit.
`timescale 1ns/1ps
`include "dchs_defs.svh"
module dchs_host_select (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic I_CHANNEL_PICK,
  input wire logic I_REG_ADDR_BIT_ZERO,
  input wire logic I_REG_ADDR_BIT_ONE,
  input wire logic I_REG_ADDR_BIT_TWO,
  input wire logic I_READ_STROBE_N,
  input wire logic I_WRITE_STROBE_N,
  input wire logic [7:0] I_HOST_DATA_BUS,
  output logic [7:0] O_HOST_DATA_BUS,
  output logic O_HOST_DATA_BUS_OE,
  input wire logic I_CARRIER_DETECT_N_A,
  input wire logic I_CARRIER_DETECT_N_B,
  input wire logic I_CLEAR_TO_SEND_N_A,
  input wire logic I_CLEAR_TO_SEND_N_B,
  output logic O_TX_ALLOW_A,
  output logic O_TX_ALLOW_B
);
  typedef struct packed {
    logic rd_n_d;
    logic wr_n_d;
    logic chan_a;
    logic oe;
    dchs_pkg::dchs_byte_t dout;
  } dchs_top_s;
  dchs_top_s st_reg;
  dchs_top_s st_next;

  dchs_pkg::dchs_addr_t addr;
  dchs_pkg::dchs_byte_t rdata_a;
  dchs_pkg::dchs_byte_t rdata_b;
  logic auto_cts_a;
  logic auto_cts_b;
  logic bcast_a;
  logic bcast_b;
  logic rd_fall;
  logic wr_rise;
  logic wr_a;
  logic wr_b;
  logic pick_a;

  assign addr = {I_REG_ADDR_BIT_TWO, I_REG_ADDR_BIT_ONE,
    I_REG_ADDR_BIT_ZERO};
  // Pick is only meaningful with select low
  assign pick_a = !I_CS_N ? I_CHANNEL_PICK : st_reg.chan_a;
  assign rd_fall = st_reg.rd_n_d && !I_READ_STROBE_N && !I_CS_N;
  // Write lands on rising strobe; select must still be low then
  assign wr_rise = !st_reg.wr_n_d && I_WRITE_STROBE_N && !I_CS_N;
  // Broadcast taken from channel A copy, the one software sets first
  assign wr_a = wr_rise && (pick_a || bcast_a);
  assign wr_b = wr_rise && (!pick_a || bcast_a);

  dchs_chan_regs u_chan_a (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_wr(wr_a),
    .i_addr(addr),
    .i_wdata(I_HOST_DATA_BUS),
    .i_cd_n(I_CARRIER_DETECT_N_A),
    .i_cts_n(I_CLEAR_TO_SEND_N_A),
    .o_rdata(rdata_a),
    .o_auto_cts(auto_cts_a),
    .o_bcast(bcast_a)
  );

  dchs_chan_regs u_chan_b (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_wr(wr_b),
    .i_addr(addr),
    .i_wdata(I_HOST_DATA_BUS),
    .i_cd_n(I_CARRIER_DETECT_N_B),
    .i_cts_n(I_CLEAR_TO_SEND_N_B),
    .o_rdata(rdata_b),
    .o_auto_cts(auto_cts_b),
    .o_bcast(bcast_b)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rd_n_d = I_READ_STROBE_N;
    st_next.wr_n_d = I_WRITE_STROBE_N;
    st_next.chan_a = pick_a;
    if (rd_fall) begin
      st_next.dout = pick_a ? rdata_a : rdata_b;
    end
    st_next.oe = !I_CS_N && !I_READ_STROBE_N;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_reg <= '{rd_n_d: 1'b1, wr_n_d: 1'b1, chan_a: 1'b0, oe: 1'b0,
        dout: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_HOST_DATA_BUS = st_reg.dout;
  assign O_HOST_DATA_BUS_OE = st_reg.oe;
  // Flow gate: status only unless auto mode is on
  assign O_TX_ALLOW_A = !auto_cts_a || !I_CLEAR_TO_SEND_N_A;
  assign O_TX_ALLOW_B = !auto_cts_b || !I_CLEAR_TO_SEND_N_B;

  // Bus drive follows a selected read only
  bus_float_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) I_CS_N
    |=> !O_HOST_DATA_BUS_OE)
    else $error("bus driven while deselected");
  oe_on_read_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (!I_CS_N && !I_READ_STROBE_N)
    |=> O_HOST_DATA_BUS_OE)
    else $error("bus not driven during read");
  oe_off_idle_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) I_READ_STROBE_N
    |=> !O_HOST_DATA_BUS_OE)
    else $error("bus driven without read strobe");
  read_data_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (rd_fall && I_CHANNEL_PICK)
    |=> O_HOST_DATA_BUS == $past(rdata_a))
    else $error("read data wrong");
  read_chan_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (rd_fall && !I_CHANNEL_PICK)
    |=> O_HOST_DATA_BUS == $past(rdata_b))
    else $error("channel B read data wrong");
  read_once_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) rd_fall
    |=> !rd_fall)
    else $error("read taken twice");
  data_hold_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !rd_fall
    |=> $stable(O_HOST_DATA_BUS))
    else $error("read data moved without read");
  data_cs_hold_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) I_CS_N
    |=> $stable(O_HOST_DATA_BUS))
    else $error("read data moved while deselected");
  // A late write would hit whichever channel the last access picked
  no_write_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) I_CS_N
    |-> !wr_a && !wr_b)
    else $error("write while deselected");
  pick_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (wr_rise && !I_CHANNEL_PICK && !bcast_a)
    |-> wr_b && !wr_a)
    else $error("pick 0 must hit channel B");
  pick_a_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (wr_rise && I_CHANNEL_PICK && !bcast_a)
    |-> wr_a && !wr_b)
    else $error("pick 1 must hit channel A");
  bcast_both_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (wr_rise && bcast_a)
    |-> wr_a && wr_b)
    else $error("broadcast missed a channel");
  pick_hold_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) I_CS_N
    |=> st_reg.chan_a == $past(st_reg.chan_a))
    else $error("pick sampled while deselected");
  pick_take_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !I_CS_N
    |=> st_reg.chan_a == $past(I_CHANNEL_PICK))
    else $error("pick not taken while selected");
  wr_once_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) wr_rise
    |=> !wr_rise)
    else $error("write taken twice");
  wr_edge_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) wr_rise
    |-> !$past(I_WRITE_STROBE_N))
    else $error("write without strobe rise");
  write_chan_a_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (wr_a && addr != `DCHS_ADDR_MSR)
    |=> u_chan_a.st_reg.regs[$past(addr)] == $past(I_HOST_DATA_BUS))
    else $error("channel A write lost");
  write_chan_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (wr_b && addr != `DCHS_ADDR_MSR)
    |=> u_chan_b.st_reg.regs[$past(addr)] == $past(I_HOST_DATA_BUS))
    else $error("channel B write lost");
  hold_chan_a_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !wr_a
    |=> $stable(u_chan_a.st_reg.regs[`DCHS_ADDR_AFR]))
    else $error("channel A changed without write");
  hold_chan_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !wr_b
    |=> $stable(u_chan_b.st_reg.regs[`DCHS_ADDR_AFR]))
    else $error("channel B changed without write");
  // Auto mode is the only path that stalls transmit
  flow_gate_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !auto_cts_a
    |-> O_TX_ALLOW_A)
    else $error("transmit gated without auto mode");
  flow_free_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !auto_cts_b
    |-> O_TX_ALLOW_B)
    else $error("channel B gated without auto mode");
  gate_chan_a_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (auto_cts_a && I_CLEAR_TO_SEND_N_A)
    |-> !O_TX_ALLOW_A)
    else $error("channel A not gated in auto mode");
  gate_chan_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) (auto_cts_b && I_CLEAR_TO_SEND_N_B)
    |-> !O_TX_ALLOW_B)
    else $error("channel B not gated in auto mode");
  ready_chan_a_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !I_CLEAR_TO_SEND_N_A
    |-> O_TX_ALLOW_A)
    else $error("channel A stalled with modem ready");
  ready_chan_b_a: assert property (@(posedge I_MCLK)
    disable iff (!I_RST_N) !I_CLEAR_TO_SEND_N_B
    |-> O_TX_ALLOW_B)
    else $error("channel B stalled with modem ready");
endmodule

// ### dchs_host_model.sv
// Host CPU model for the host select block: select, address, strobes.
// Assumes the bench calls wr and rd; all changes follow a rising edge.
`timescale 1ns/1ps
module dchs_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_dout,
  input wire logic i_oe,
  output logic o_cs_n,
  output logic o_pick,
  output logic [2:0] o_addr,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_data
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_pick, o_addr, o_data} = 15'h7000;
  end
  task wr(input logic c, input logic p, input logic [2:0] a,
          input logic [7:0] d);
    @(posedge i_clk);
    {o_cs_n, o_pick, o_addr, o_data, o_wr_n} <= {c, p, a, d, 1'h0};
    repeat (2) @(posedge i_clk);
    o_wr_n <= 1'b1;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released bus: show the inverse, never a stale byte
    o_data <= ~d;
    @(posedge i_clk);
  endtask
  task rd(input logic c, input logic p, input logic [2:0] a,
          output logic [7:0] q, output logic oe);
    @(posedge i_clk);
    {o_cs_n, o_pick, o_addr, o_rd_n} <= {c, p, a, 1'h0};
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    q = i_dout;
    oe = i_oe;
    @(posedge i_clk);
    {o_cs_n, o_rd_n} <= 2'h3;
    repeat (2) @(posedge i_clk);
  endtask
endmodule

// ### dchs_host_select_tb_top.sv
// Self-checking bench for the host select block.
// Assumes the host model above; modem pins driven here.
`timescale 1ns/1ps
`include "dchs_defs.svh"
module dchs_host_select_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, pick, rd_n, wr_n, oe, txa, txb, o;
  logic cd_a_n, cd_b_n, cts_a_n, cts_b_n;
  logic [2:0] addr;
  logic [7:0] din, dout, q;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  dchs_host_model dchs_host_model_i (.i_clk(clk), .i_dout(dout),
    .i_oe(oe), .o_cs_n(cs_n), .o_pick(pick), .o_addr(addr),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(din));
  dchs_host_select dchs_host_select_i (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_CS_N(cs_n), .I_CHANNEL_PICK(pick), .I_REG_ADDR_BIT_ZERO(addr[0]),
    .I_REG_ADDR_BIT_ONE(addr[1]), .I_REG_ADDR_BIT_TWO(addr[2]),
    .I_READ_STROBE_N(rd_n), .I_WRITE_STROBE_N(wr_n),
    .I_HOST_DATA_BUS(din), .O_HOST_DATA_BUS(dout),
    .O_HOST_DATA_BUS_OE(oe), .I_CARRIER_DETECT_N_A(cd_a_n),
    .I_CARRIER_DETECT_N_B(cd_b_n), .I_CLEAR_TO_SEND_N_A(cts_a_n),
    .I_CLEAR_TO_SEND_N_B(cts_b_n), .O_TX_ALLOW_A(txa), .O_TX_ALLOW_B(txb));
  initial forever #20 clk = ~clk;
  task w(input logic c, input logic p, input logic [2:0] a,
         input logic [7:0] d);
    dchs_host_model_i.wr(c, p, a, d);
  endtask
  task r(input logic c, input logic p, input logic [2:0] a);
    dchs_host_model_i.rd(c, p, a, q, o);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_steer;
    r(1'b0, 1'b1, 3'h0);
    chk(q, `DCHS_REG_RESET);
    w(1'b0, 1'b1, 3'h0, 8'h5A);
    w(1'b0, 1'b0, 3'h0, 8'hC3);
    r(1'b0, 1'b1, 3'h0);
    chk(q, 8'h5A);
    chk({7'h00, o}, 8'h01);
    r(1'b0, 1'b0, 3'h0);
    chk(q, 8'hC3);
    // Skips the register addresses with side effects
    for (int a = 3; a < 8; a++)
      if (a != 6) w(1'b0, 1'b1, 3'(a), 8'(8'h01 << (a - 3)));
    for (int a = 3; a < 8; a++) begin
      if (a != 6) begin
        r(1'b0, 1'b1, 3'(a));
        chk(q, 8'(8'h01 << (a - 3)));
      end
    end
  endtask
  task t_nocs;
    w(1'b1, 1'b0, 3'h0, 8'hFF);
    r(1'b1, 1'b1, 3'h0);
    chk({7'h00, o}, 8'h00);
    r(1'b0, 1'b1, 3'h0);
    chk(q, 8'h5A);
    r(1'b0, 1'b0, 3'h0);
    chk(q, 8'hC3);
  endtask
  task t_bcast;
    w(1'b0, 1'b1, `DCHS_ADDR_AFR, 8'h01);
    w(1'b0, 1'b0, 3'h3, 8'h77);
    r(1'b0, 1'b1, 3'h3);
    chk(q, 8'h77);
    r(1'b0, 1'b0, 3'h3);
    chk(q, 8'h77);
    w(1'b0, 1'b1, `DCHS_ADDR_AFR, 8'h00);
    w(1'b0, 1'b0, 3'h3, 8'h66);
    r(1'b0, 1'b1, 3'h3);
    chk(q, 8'h77);
    r(1'b0, 1'b0, 3'h3);
    chk(q, 8'h66);
  endtask
  task t_reset;
    @(posedge clk);
    cts_a_n <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(dout, `DCHS_REG_RESET);
    chk({6'h00, txa, txb}, 8'h03);
    r(1'b0, 1'b1, 3'h0);
    chk(q, `DCHS_REG_RESET);
  endtask
  task t_modem;
    cd_a_n <= 1'b0;
    cts_b_n <= 1'b0;
    r(1'b0, 1'b1, `DCHS_ADDR_MSR);
    chk(q & 8'h90, 8'h80);
    r(1'b0, 1'b0, `DCHS_ADDR_MSR);
    chk(q & 8'h90, 8'h10);
    chk({6'h00, txa, txb}, 8'h03);
    w(1'b0, 1'b1, `DCHS_ADDR_EFR, 8'h80);
    @(negedge clk);
    chk({6'h00, txa, txb}, 8'h01);
    @(posedge clk);
    cts_a_n <= 1'b0;
    @(negedge clk);
    chk({6'h00, txa, txb}, 8'h03);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    {cd_a_n, cd_b_n, cts_a_n, cts_b_n} = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_steer;
    t_nocs;
    t_bcast;
    t_modem;
    t_reset;
    close_out;
  end
endmodule
